// File: design/supply_ctrl_pkg.sv
// Function
// - Restart bit restarts its timer at frame end, on phase first; bit self-clears next frame.
// - Three-bit period code selects one of eight periods; code zero after reset.
// - On-time codes zero to four select on-times; larger codes void the whole write.
// - Gated drive makes the timer on phase the AND of waveform and gate input.
// - Gate input only affects high-side output use, never wake-input monitoring.
// - Unchanged timer fields with restart clear leave the running timers alone.
// - Bit 7 selects LIN listen-only operation; reset value zero.
// - Bit 6 enables LIN transmit timeout detection; reset value one.
// - Bit 5 loops CAN transmit data back to receive data; reset value zero.
// - Partial networking needs receiver on; wake pattern gives bias and interrupt.
// - Reset threshold codes 00 to 11 map to fourth through first level.
// - Watchdog window code selects four times; writes blocked unless unlock is set.
// - Changed watchdog window applies at frame end and restarts the watchdog.
// - Regulator-supply lockout keeps outputs off until status clears; else auto recovery.
// - Main-supply lockout behaves the same for main-supply outputs and status.
// - Standby disables both lockouts.
// - Bits 21 and 20 enable regulator-supply over and undervoltage shutdown.
// - Main overvoltage without shutdown keeps outputs on while charge pump stays high.
// - Bit 18 enables main undervoltage shutdown; primary undervoltage then forces fail-safe.
// - In Active mode regulator supply below nonzero threshold raises interrupt and warning flag.
// - Main-supply group is outputs one to fourteen plus both bridge drivers.
// - An ignored invalid write sets the invalid command flag.
package supply_ctrl_pkg;

    localparam logic [6:0]  TIMER_CTRL_ADDR   = 7'h02;
    localparam logic [6:0]  SUPPLY_CTRL_ADDR  = 7'h03;
    localparam logic [23:0] TIMER_CTRL_RESET  = 24'h000040;
    localparam logic [23:0] SUPPLY_CTRL_RESET = 24'hFC0000;
    localparam logic [23:0] TIMER_CTRL_MASK   = 24'hFFFFFF;
    localparam logic [23:0] SUPPLY_CTRL_MASK  = 24'hFC03FF;

    localparam int FIRST_TIMER_RESTART_BIT = 23;
    localparam int T1_GATED_BIT   = 22;
    localparam int T1_ON_LSB      = 19;
    localparam int FIRST_TIMER_PERIOD_SELECT_LSB     = 16;
    localparam int SECOND_TIMER_RESTART_BIT = 15;
    localparam int T2_GATED_BIT   = 14;
    localparam int T2_ON_LSB      = 11;
    localparam int SECOND_TIMER_PERIOD_SELECT_LSB     = 8;
    localparam int LIN_LISTEN_BIT = 7;
    localparam int LIN_TOUT_BIT   = 6;
    localparam int CAN_LOOP_BIT   = 5;
    localparam int PNW_BIT        = 4;
    localparam int RST_TH_LSB     = 2;
    localparam int WD_WIN_LSB     = 0;

    localparam int REG_LOCK_BIT   = 23;
    localparam int MAIN_LOCK_BIT  = 22;
    localparam int REG_OV_SD_BIT  = 21;
    localparam int REG_UV_SD_BIT  = 20;
    localparam int MAIN_OV_SD_BIT = 19;
    localparam int MAIN_UV_SD_BIT = 18;
    localparam int WARN_TH_LSB    = 0;

    localparam logic [2:0] ON_CODE_MAX = 3'h4;

    // Decoded timer settings for one timer.
    typedef struct packed {
        logic [2:0] period_sel;
        logic [2:0] on_sel;
        logic       gated;
    } timer_cfg_t;

    // One completed serial write, presented at chip-select release.
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [23:0] data;
    } frame_t;

endpackage : supply_ctrl_pkg

// File: design/timer_transceiver_supply_control.sv
`timescale 1ns/1ps
module timer_transceiver_supply_control
    import supply_ctrl_pkg::*;
(
    input  wire logic               i_clk_sys,
    input  wire logic               i_resetn,
    input  wire supply_ctrl_pkg::frame_t i_frame,
    input  wire logic               i_frame_start,
    input  wire logic [6:0]         i_read_addr,
    output logic [23:0]             o_read_data,
    input  wire logic               i_watchdog_config_unlock,
    input  wire logic               i_can_receiver_enable,
    input  wire logic               i_can_wake_pattern,
    input  wire logic               i_gate_drive,
    input  wire logic [1:0]         i_first_wave,
    input  wire logic [1:0]         i_second_wave,
    input  wire logic               i_active_mode,
    input  wire logic               i_standby_mode,
    input  wire logic               i_reg_ov,
    input  wire logic               i_reg_uv,
    input  wire logic               i_main_ov,
    input  wire logic               i_main_uv,
    input  wire logic               i_charge_pump_low_threshold,
    input  wire logic               i_primary_uv,
    input  wire logic               i_reg_status_clear,
    input  wire logic               i_main_status_clear,
    input  wire logic [9:0]         i_reg_supply_level,
    input  wire logic               i_warning_clear,
    input  wire logic               i_invalid_clear,
    output supply_ctrl_pkg::timer_cfg_t o_first_cfg,
    output supply_ctrl_pkg::timer_cfg_t o_second_cfg,
    output logic                    o_first_timer_restart,
    output logic                    o_second_timer_restart,
    output logic                    o_first_hs_on,
    output logic                    o_second_hs_on,
    output logic                    o_first_wake_on,
    output logic                    o_second_wake_on,
    output logic                    o_lin_listen_only,
    output logic                    o_lin_transmit_timeout_enable,
    output logic                    o_can_loop_enable,
    output logic                    o_partial_networking_enable,
    output logic                    o_transceiver_bias_state,
    output logic [1:0]              o_primary_regulator_reset_threshold,
    output logic [1:0]              o_watchdog_window_select,
    output logic                    o_watchdog_restart,
    output logic                    o_reg_outputs_off,
    output logic                    o_main_outputs_off,
    output logic                    o_fail_safe,
    output logic                    o_regulator_supply_warning_flag,
    output logic                    o_interrupt_output_low,
    output logic                    o_invalid_command_flag,
    output logic                    o_reg_status_ov,
    output logic                    o_reg_status_uv,
    output logic                    o_main_status_ov,
    output logic                    o_main_status_uv
);
    import supply_ctrl_pkg::*;

    //------------------------------------------------------------------
    // Reset synchroniser
    //------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Release the asynchronous reset through two flops.
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rstn = rst_sync_reg;

    //------------------------------------------------------------------
    // Write decode
    //------------------------------------------------------------------
    logic [23:0] timer_reg;
    logic [23:0] supply_reg;
    logic [23:0] timer_next;
    logic        timer_wr;
    logic        supply_wr;
    logic        on_invalid;

    // An on-time code above four voids the whole timer write.
    always_comb
    begin
        timer_wr   = i_frame.valid && (i_frame.addr == TIMER_CTRL_ADDR);
        supply_wr  = i_frame.valid && (i_frame.addr == SUPPLY_CTRL_ADDR);
        on_invalid = (i_frame.data[T1_ON_LSB +: 3] > ON_CODE_MAX) ||
                     (i_frame.data[T2_ON_LSB +: 3] > ON_CODE_MAX);
        timer_next = i_frame.data & TIMER_CTRL_MASK;
        if (!i_watchdog_config_unlock)
        begin
            timer_next[WD_WIN_LSB +: 2] = timer_reg[WD_WIN_LSB +: 2];
        end
        if (!i_can_receiver_enable)
        begin
            timer_next[PNW_BIT] = 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Control registers
    //------------------------------------------------------------------
    // Timer and transceiver register; restart bits clear at the next frame.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_reg <= TIMER_CTRL_RESET;
        end
        else if (timer_wr && !on_invalid)
        begin
            timer_reg <= timer_next;
        end
        else if (i_frame_start)
        begin
            timer_reg[FIRST_TIMER_RESTART_BIT] <= 1'b0;
            timer_reg[SECOND_TIMER_RESTART_BIT] <= 1'b0;
        end
    end

    // Supply protection register; reserved bits never store.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            supply_reg <= SUPPLY_CTRL_RESET;
        end
        else if (supply_wr)
        begin
            supply_reg <= i_frame.data & SUPPLY_CTRL_MASK;
        end
    end

    //------------------------------------------------------------------
    // Frame-end strobes
    //------------------------------------------------------------------
    // Restart only on request; unchanged fields without it do nothing.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            o_first_timer_restart  <= 1'b0;
            o_second_timer_restart <= 1'b0;
            o_watchdog_restart     <= 1'b0;
        end
        else
        begin
            o_first_timer_restart  <= timer_wr && !on_invalid &&
                                      timer_next[FIRST_TIMER_RESTART_BIT];
            o_second_timer_restart <= timer_wr && !on_invalid &&
                                      timer_next[SECOND_TIMER_RESTART_BIT];
            o_watchdog_restart     <= timer_wr && !on_invalid &&
                (timer_next[WD_WIN_LSB +: 2] != timer_reg[WD_WIN_LSB +: 2]);
        end
    end

    //------------------------------------------------------------------
    // Timer outputs
    //------------------------------------------------------------------
    // Gated drive applies to high-side use only; wake monitoring is ungated.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            o_first_hs_on    <= 1'b0;
            o_second_hs_on   <= 1'b0;
            o_first_wake_on  <= 1'b0;
            o_second_wake_on <= 1'b0;
        end
        else
        begin
            o_first_hs_on    <= i_first_wave[0] &
                                (~timer_reg[T1_GATED_BIT] | i_gate_drive);
            o_second_hs_on   <= i_second_wave[0] &
                                (~timer_reg[T2_GATED_BIT] | i_gate_drive);
            o_first_wake_on  <= i_first_wave[1];
            o_second_wake_on <= i_second_wave[1];
        end
    end

    //------------------------------------------------------------------
    // Supply status and lockout
    //------------------------------------------------------------------
    logic reg_lock;
    logic main_lock;
    logic reg_fault;
    logic main_fault;

    // Standby overrides both lockouts.
    always_comb
    begin
        reg_lock   = supply_reg[REG_LOCK_BIT] && !i_standby_mode;
        main_lock  = supply_reg[MAIN_LOCK_BIT] && !i_standby_mode;
        reg_fault  = (i_reg_ov && supply_reg[REG_OV_SD_BIT]) ||
                     (i_reg_uv && supply_reg[REG_UV_SD_BIT]);
        main_fault = (i_main_ov && (supply_reg[MAIN_OV_SD_BIT] ||
                                    i_charge_pump_low_threshold)) ||
                     (i_main_uv && supply_reg[MAIN_UV_SD_BIT]);
    end

    // Status bits: set wins over clear; without lockout they follow the fault.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            o_reg_status_ov  <= 1'b0;
            o_reg_status_uv  <= 1'b0;
            o_main_status_ov <= 1'b0;
            o_main_status_uv <= 1'b0;
        end
        else
        begin
            o_reg_status_ov  <= i_reg_ov |
                (o_reg_status_ov & reg_lock & ~i_reg_status_clear);
            o_reg_status_uv  <= i_reg_uv |
                (o_reg_status_uv & reg_lock & ~i_reg_status_clear);
            o_main_status_ov <= i_main_ov |
                (o_main_status_ov & main_lock & ~i_main_status_clear);
            o_main_status_uv <= i_main_uv |
                (o_main_status_uv & main_lock & ~i_main_status_clear);
        end
    end

    // Outputs one to fourteen and both bridges form the main group.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            o_reg_outputs_off  <= 1'b0;
            o_main_outputs_off <= 1'b0;
            o_fail_safe        <= 1'b0;
        end
        else
        begin
            o_reg_outputs_off  <= reg_fault | (reg_lock & o_reg_outputs_off &
                (o_reg_status_ov | o_reg_status_uv)) | o_fail_safe;
            o_main_outputs_off <= main_fault | (main_lock & o_main_outputs_off &
                (o_main_status_ov | o_main_status_uv)) | o_fail_safe;
            o_fail_safe        <= o_fail_safe |
                (i_primary_uv & ((i_main_uv & supply_reg[MAIN_UV_SD_BIT]) |
                                 (i_reg_uv & supply_reg[REG_UV_SD_BIT])));
        end
    end

    //------------------------------------------------------------------
    // Early warning, invalid command and wake pattern
    //------------------------------------------------------------------
    logic warn_now;
    assign warn_now = i_active_mode && (supply_reg[WARN_TH_LSB +: 10] != 10'h000) &&
                      (i_reg_supply_level < supply_reg[WARN_TH_LSB +: 10]);

    // Sticky flags whose set wins over their clear.
    always_ff @(posedge i_clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            o_regulator_supply_warning_flag <= 1'b0;
            o_invalid_command_flag          <= 1'b0;
            o_transceiver_bias_state        <= 1'b0;
        end
        else
        begin
            o_regulator_supply_warning_flag <= warn_now |
                (o_regulator_supply_warning_flag & ~i_warning_clear);
            o_invalid_command_flag <= (timer_wr & on_invalid) |
                (o_invalid_command_flag & ~i_invalid_clear);
            o_transceiver_bias_state <= (timer_reg[PNW_BIT] & i_can_wake_pattern) |
                (o_transceiver_bias_state & ~i_warning_clear);
        end
    end

    // Interrupt pin is low while a warning or wake event is pending.
    assign o_interrupt_output_low = ~(o_regulator_supply_warning_flag |
                                      o_transceiver_bias_state);

    //------------------------------------------------------------------
    // Field outputs and read back
    //------------------------------------------------------------------
    assign o_first_cfg  = '{timer_reg[FIRST_TIMER_PERIOD_SELECT_LSB +: 3], timer_reg[T1_ON_LSB +: 3],
                            timer_reg[T1_GATED_BIT]};
    assign o_second_cfg = '{timer_reg[SECOND_TIMER_PERIOD_SELECT_LSB +: 3], timer_reg[T2_ON_LSB +: 3],
                            timer_reg[T2_GATED_BIT]};
    assign o_lin_listen_only             = timer_reg[LIN_LISTEN_BIT];
    assign o_lin_transmit_timeout_enable = timer_reg[LIN_TOUT_BIT];
    assign o_can_loop_enable             = timer_reg[CAN_LOOP_BIT];
    assign o_partial_networking_enable   = timer_reg[PNW_BIT];
    assign o_primary_regulator_reset_threshold = timer_reg[RST_TH_LSB +: 2];
    assign o_watchdog_window_select      = timer_reg[WD_WIN_LSB +: 2];

    // Read multiplexer; other addresses read zero.
    always_comb
    begin
        case (i_read_addr)
            TIMER_CTRL_ADDR:  o_read_data = timer_reg;
            SUPPLY_CTRL_ADDR: o_read_data = supply_reg & SUPPLY_CTRL_MASK;
            default:          o_read_data = 24'h000000;
        endcase
    end

endmodule : timer_transceiver_supply_control

// File: tb/ctrl_assertions.sv
`timescale 1ns/1ps
module ctrl_assertions
    import supply_ctrl_pkg::*;
(
    input wire logic                       i_clk_sys,
    input wire logic                       i_resetn,
    input wire supply_ctrl_pkg::frame_t     i_frame,
    input wire logic [6:0]                 i_read_addr,
    input wire logic [23:0]                o_read_data,
    input wire logic                       i_watchdog_config_unlock,
    input wire logic                       i_can_receiver_enable,
    input wire logic                       i_gate_drive,
    input wire logic [9:0]                 i_reg_supply_level,
    input wire logic                       i_active_mode,
    input wire logic                       i_warning_clear,
    input wire logic                       i_invalid_clear,
    input wire supply_ctrl_pkg::timer_cfg_t o_first_cfg,
    input wire supply_ctrl_pkg::timer_cfg_t o_second_cfg,
    input wire logic                       o_first_timer_restart,
    input wire logic                       o_partial_networking_enable,
    input wire logic [1:0]                 o_watchdog_window_select,
    input wire logic                       o_watchdog_restart,
    input wire logic                       o_regulator_supply_warning_flag,
    input wire logic                       o_invalid_command_flag,
    input wire logic                       o_first_hs_on
);
    import supply_ctrl_pkg::*;

    logic tw;
    logic on_ok;

    // A timer write is valid only when both on-time codes are in range.
    assign tw    = i_frame.valid && (i_frame.addr == TIMER_CTRL_ADDR);
    assign on_ok = (i_frame.data[21:19] <= ON_CODE_MAX) && (i_frame.data[13:11] <= ON_CODE_MAX);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_good_wr;
        tw && on_ok;
    endsequence

    sequence s_restart_seen;
        ##[1:2] o_first_timer_restart;
    endsequence

    a_restart_pulse: assert property (s_good_wr ##0 i_frame.data[23] |-> s_restart_seen)
        else $error("timer restart pulse missing");
    a_no_restart: assert property (tw && !i_frame.data[23] |=> !o_first_timer_restart)
        else $error("restart pulse without request");
    a_invalid_flag: assert property (tw && !on_ok && !i_invalid_clear |->
        ##[1:2] o_invalid_command_flag)
        else $error("invalid flag not set");
    a_invalid_ignored: assert property (tw && !on_ok |=>
        $stable(o_first_cfg) && $stable(o_second_cfg))
        else $error("invalid write changed timers");
    a_window_locked: assert property (tw && !i_watchdog_config_unlock |=>
        $stable(o_watchdog_window_select))
        else $error("locked window field changed");
    a_wd_restart: assert property (s_good_wr ##0 (i_watchdog_config_unlock &&
        (i_frame.data[1:0] != o_watchdog_window_select)) |-> ##[1:2] o_watchdog_restart)
        else $error("watchdog restart missing");
    a_pnw_refused: assert property (s_good_wr ##0 !i_can_receiver_enable |=>
        !o_partial_networking_enable)
        else $error("partial networking set without receiver");
    a_gated_off: assert property (o_first_cfg.gated && !i_gate_drive |=> !o_first_hs_on)
        else $error("gated output on without gate");
    a_warn_raise: assert property (i_active_mode && (i_read_addr == SUPPLY_CTRL_ADDR) &&
        (o_read_data[9:0] != 10'h000) && (i_reg_supply_level < o_read_data[9:0]) &&
        !i_warning_clear |-> ##[1:2] o_regulator_supply_warning_flag)
        else $error("early warning not raised");
endmodule : ctrl_assertions

bind timer_transceiver_supply_control ctrl_assertions chk_u (.*);

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model
    import supply_ctrl_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_send,
    input  wire logic [6:0]        i_addr,
    input  wire logic [23:0]       i_data,
    output supply_ctrl_pkg::frame_t o_frame,
    output logic                   o_frame_start,
    output logic                   o_busy
);
    import supply_ctrl_pkg::*;

    logic [2:0] step;

    // Everything starts idle.
    initial
    begin
        o_frame       = '0;
        o_frame_start = 1'b0;
        o_busy        = 1'b0;
        step          = 3'h0;
    end

    // One request plays one frame: select falls, the word shifts, select rises.
    always @(posedge i_clk_sys)
    begin
        o_frame_start <= !o_busy && i_send;
        o_frame.valid <= o_busy && (step == 3'h3); // Whole word at select release.
        if (o_busy && (step == 3'h3))
        begin
            o_frame.addr <= i_addr;
            o_frame.data <= i_data;
        end
        else if (o_frame.valid)
        begin
            o_frame.addr <= ~o_frame.addr; // Released lines do not keep their value.
            o_frame.data <= ~o_frame.data;
        end
        if (!o_busy && i_send)
        begin
            o_busy <= 1'b1;
            step   <= 3'h0;
        end
        else if (o_busy)
        begin
            step <= step + 3'h1;
            if (step == 3'h4)
                o_busy <= 1'b0;
        end
    end
endmodule : host_model

// File: tb/timer_transceiver_supply_control_test.sv
`timescale 1ns/1ps
module timer_transceiver_supply_control_test;
    import supply_ctrl_pkg::*;

    typedef struct packed { logic fl; logic [23:0] v; } note_t;

    frame_t      i_frame;
    logic        i_clk_sys = 1'b0, i_resetn = 1'b0, i_frame_start, send = 1'b0, busy, probe = 1'b0;
    logic [6:0]  i_read_addr = 7'h02, h_addr = 7'h00;
    logic [23:0] o_read_data, h_data = 24'h0, cur, d;
    logic        i_watchdog_config_unlock = 1'b0, i_can_receiver_enable = 1'b0, i_gate_drive = 1'b0;
    logic        i_can_wake_pattern = 1'b0, i_active_mode = 1'b1, i_standby_mode = 1'b0;
    logic        i_reg_ov = 1'b0, i_main_ov = 1'b0, i_charge_pump_low_threshold = 1'b0;
    logic        i_primary_uv = 1'b0, uv = 1'b0, st_clr = 1'b0, fl_clr = 1'b0;
    logic [1:0]  i_first_wave = 2'h0;
    logic [9:0]  i_reg_supply_level = 10'h0FF;
    wire  [1:0]  i_second_wave = i_first_wave;
    wire         i_reg_uv = uv, i_main_uv = uv, i_reg_status_clear = st_clr;
    wire         i_main_status_clear = st_clr, i_warning_clear = fl_clr, i_invalid_clear = fl_clr;
    timer_cfg_t  o_first_cfg, o_second_cfg;
    logic        o_first_timer_restart, o_second_timer_restart, o_first_hs_on, o_second_hs_on;
    logic        o_first_wake_on, o_second_wake_on, o_lin_listen_only, o_can_loop_enable;
    logic        o_lin_transmit_timeout_enable, o_partial_networking_enable, o_watchdog_restart;
    logic        o_transceiver_bias_state, o_reg_outputs_off, o_main_outputs_off, o_fail_safe;
    logic [1:0]  o_primary_regulator_reset_threshold, o_watchdog_window_select;
    logic        o_regulator_supply_warning_flag, o_interrupt_output_low, o_invalid_command_flag;
    logic        o_reg_status_ov, o_reg_status_uv, o_main_status_ov, o_main_status_uv;
    logic [6:0]  flags;
    logic [31:0] rnd = 32'hD10F;
    int          err_count = 0, comparisons = 0, cycles = 0;
    note_t       notes[$], n;

    // Flag outputs gathered into one observed word.
    assign flags = {o_invalid_command_flag, o_regulator_supply_warning_flag,
                    o_interrupt_output_low, o_first_hs_on, o_first_wake_on,
                    o_reg_outputs_off, o_main_outputs_off};

    timer_transceiver_supply_control dut_u (.*);
    host_model host_u (.i_clk_sys(i_clk_sys), .i_send(send), .i_addr(h_addr), .i_data(h_data),
                       .o_frame(i_frame), .o_frame_start(i_frame_start), .o_busy(busy));

    // The clock toggles every half period.
    always #2.5 i_clk_sys = ~i_clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic cmp_word(input logic [23:0] g, input logic [23:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t read word %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_flags(input logic [6:0] g, input logic [6:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t flags %b expected %b", $time, g, e);
        end
    endtask : cmp_flags

    // Hands one word to the host model and waits until its frame has ended.
    task automatic wr(input logic [6:0] a, input logic [23:0] v);
        @(negedge i_clk_sys);
        h_addr = a;
        h_data = v;
        send   = 1'b1;
        @(negedge i_clk_sys);
        send = 1'b0;
        repeat (10) if (busy) @(negedge i_clk_sys);
    endtask : wr

    // Notes an expected read word or flag word and asks the monitor to look.
    task automatic chk(input logic fl, input logic [6:0] a, input logic [23:0] v);
        @(negedge i_clk_sys);
        if (!fl)
            i_read_addr = a;
        notes.push_back('{fl, v});
        probe = 1'b1;
        @(negedge i_clk_sys);
        probe = 1'b0;
    endtask : chk

    task automatic wait3();
        repeat (3) @(negedge i_clk_sys);
    endtask : wait3

    // The monitor takes the oldest note once outputs have settled.
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
        if (probe)
        begin
            #1;
            n = notes.pop_front();
            if (n.fl)
                cmp_flags(flags, n.v[6:0]);
            else
                cmp_word(o_read_data, n.v);
        end
    end

    // Main sequence of scenarios.
    initial
    begin
        repeat (8) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        wait3();
        chk(0, 7'h02, 24'h000040);
        chk(0, 7'h03, 24'hFC0000);
        chk(1, 7'h00, 24'h10);
        uv = 1'b1;
        wait3();
        uv = 1'b0;
        wait3();
        chk(1, 7'h00, 24'h13);
        st_clr = 1'b1;
        @(negedge i_clk_sys);
        st_clr = 1'b0;
        wait3();
        chk(1, 7'h00, 24'h10);
        i_standby_mode = 1'b1;
        i_active_mode  = 1'b0;
        uv = 1'b1;
        wait3();
        uv = 1'b0;
        wait3();
        chk(1, 7'h00, 24'h10);
        i_standby_mode = 1'b0;
        i_active_mode  = 1'b1;
        cur = 24'h000040;
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            d = rnd[23:0];
            d[18:16] = i[2:0];
            d[10:8]  = 3'(7 - i);
            d[21:19] = 3'(i % 5);
            d[13:11] = 3'((i + 2) % 5);
            d[3:2]   = 2'h3;
            d[23] = 1'b1;
            d[15] = 1'b1;
            i_watchdog_config_unlock = i[0];
            i_can_receiver_enable    = i[1];
            cur = {d[23:2], i[0] ? d[1:0] : cur[1:0]};
            cur[4] = d[4] & i[1];
            wr(7'h02, d);
            chk(0, 7'h02, cur);
        end
        rnd = lfsr(rnd);
        wr(7'h04, rnd[23:0]);
        cur[23] = 1'b0;
        cur[15] = 1'b0;
        chk(0, 7'h02, cur);
        for (int c = 5; c < 8; c++)
        begin
            d = cur;
            d[1:0] = ~cur[1:0];
            if (c < 7)
                d[21:19] = 3'(c);
            else
                d[13:11] = 3'(c);
            wr(7'h02, d);
            chk(0, 7'h02, cur);
            chk(1, 7'h00, 24'h50);
        end
        fl_clr = 1'b1;
        @(negedge i_clk_sys);
        fl_clr = 1'b0;
        chk(1, 7'h00, 24'h10);
        cur[22] = 1'b1;
        wr(7'h02, cur);
        chk(0, 7'h02, cur);
        i_first_wave = 2'h3;
        wait3();
        chk(1, 7'h00, 24'h14);
        i_gate_drive = 1'b1;
        wait3();
        chk(1, 7'h00, 24'h1C);
        i_first_wave = 2'h0;
        i_gate_drive = 1'b0;
        rnd = lfsr(rnd);
        d = {rnd[23:10], 10'h100};
        i_reg_supply_level = 10'h200;
        wr(7'h03, d);
        chk(0, 7'h03, d & 24'hFC03FF);
        chk(1, 7'h00, 24'h10);
        i_reg_supply_level = 10'h0FF;
        wait3();
        chk(1, 7'h00, 24'h20);
        wait3();
        stop_test();
    end
endmodule : timer_transceiver_supply_control_test
